// >>> rtl/wdt_halt_wake.sv
// watchdog, halt mode control and wake-up logic with AXI4-Lite registers
// assumes core strobes for instructions, and slow oscillator ticks
// arriving as one-cycle pulses synchronous to clock
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wdt_halt_wake #(
   parameter int pa_width = 8,
   parameter int sreset_cycles = wdt_pkg::sreset_cycles
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // axi4-lite write address / data / response
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // core instruction strobes
   input wire logic halt_instr,
   input wire logic watchdog_clear_instruction,
   // slow oscillator ticks
   input wire logic internal_low_osc_tick,
   input wire logic external_low_crystal_tick,
   // wake sources
   input wire logic reset_pin_selected,
   input wire logic external_reset_pin_n,
   input wire logic [pa_width-1:0] port_a_in,
   input wire logic irq_request,
   input wire logic irq_enabled,
   input wire logic stack_full,
   // clock gating and core control
   output logic fast_clock_on,
   output logic sub_clock_on,
   output logic slow_watchdog_clock_on,
   output logic core_halted,
   output logic system_reset,
   output logic pc_sp_reset,
   output logic irq_take,
   output logic irq_pending,
   output logic power_down_flag,
   output logic timeout_flag
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] wdt_ctrl_r;
   logic [3:0] rst_flags_r;
   logic [3:0] sys_ctrl_r;
   logic [pa_width-1:0] port_a_wake_enable_r;
   logic [pa_width-1:0] port_a_prev_r;
   logic irq_armed_r;
   logic irq_pend_r;
   logic pd_r;
   logic to_r;
   wdt_pkg::pmode_e mode_r;
   logic [15:0] sreset_cnt_r;
   logic sreset_busy_r;
   logic sysrst_r;
   logic pcsp_r;
   logic take_r;

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   logic aw_held_r, w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic wr_fire;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

   // address and data may arrive in either order
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_r <= 1'b0;
         end
      end
   end

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == wdt_pkg::wdt_ctrl_off) ||
               (a == wdt_pkg::rst_flags_off) ||
               (a == wdt_pkg::sys_ctrl_off) ||
               (a == wdt_pkg::wake_en_off) ||
               (a == wdt_pkg::status_off) ||
               (a == wdt_pkg::cmd_off);
   endfunction

   // write response; unmapped gets slverr
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= mapped(aw_addr_r) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // decoded write strobes (low byte lane carries every register)
   logic wr_lane0;
   logic wr_wdt, wr_flags, wr_sys, wr_wake, wr_cmd;
   assign wr_lane0 = wr_fire && w_strb_r[0];
   assign wr_wdt = wr_lane0 && aw_addr_r == wdt_pkg::wdt_ctrl_off;
   assign wr_flags = wr_lane0 && aw_addr_r == wdt_pkg::rst_flags_off;
   assign wr_sys = wr_lane0 && aw_addr_r == wdt_pkg::sys_ctrl_off;
   assign wr_wake = wr_lane0 && aw_addr_r == wdt_pkg::wake_en_off;
   assign wr_cmd = wr_lane0 && aw_addr_r == wdt_pkg::cmd_off;

   // ----------------------------------------------------------------
   // watchdog control
   // ----------------------------------------------------------------
   logic [4:0] watchdog_enable_field;
   logic [2:0] period_select_field;
   logic wdt_on, en_illegal_wr;
   logic halt_evt, clr_evt, pin_low;
   assign watchdog_enable_field = wdt_ctrl_r[wdt_pkg::en_lsb +: 5];
   assign period_select_field = wdt_ctrl_r[wdt_pkg::sel_lsb +: 3];
   assign wdt_on = watchdog_enable_field == wdt_pkg::en_on_code;
   assign en_illegal_wr = wr_wdt &&
      w_data_r[wdt_pkg::en_lsb +: 5] != wdt_pkg::en_on_code &&
      w_data_r[wdt_pkg::en_lsb +: 5] != wdt_pkg::en_off_code;
   assign halt_evt = (halt_instr ||
      (wr_cmd && w_data_r[wdt_pkg::cmd_halt_bit])) &&
      mode_r == wdt_pkg::mode_run;
   assign clr_evt = watchdog_clear_instruction ||
      (wr_cmd && w_data_r[wdt_pkg::cmd_clear_bit]);
   assign pin_low = reset_pin_selected && !external_reset_pin_n;

   // control register; the warm pc/sp reset leaves it alone
   always_ff @(posedge clock) begin
      if (!rst_n || sysrst_r) begin
         wdt_ctrl_r <= wdt_pkg::wdt_ctrl_rst;
      end else if (wr_wdt) begin
         wdt_ctrl_r <= w_data_r[7:0];
      end
   end

   // system control and port a wake enables
   always_ff @(posedge clock) begin
      if (!rst_n || sysrst_r) begin
         sys_ctrl_r <= wdt_pkg::sys_ctrl_rst;
         port_a_wake_enable_r <= '0;
      end else begin
         if (wr_sys) begin
            sys_ctrl_r <= w_data_r[3:0];
         end
         if (wr_wake) begin
            port_a_wake_enable_r <= w_data_r[pa_width-1:0];
         end
      end
   end

   // slow clock source follows the select bit
   logic slow_tick, wdt_clear, wdt_ovf;
   assign slow_tick = sys_ctrl_r[wdt_pkg::osc_sel_bit] ?
      external_low_crystal_tick : internal_low_osc_tick;
   assign wdt_clear = en_illegal_wr || clr_evt || halt_evt ||
      pin_low;

   wdt_counter #(
      .width(18)
   ) u_counter (
      .clock(clock),
      .rst_n(rst_n),
      .slow_tick(slow_tick),
      .run(wdt_on),
      .clear(wdt_clear),
      .period_sel(period_select_field),
      .overflow(wdt_ovf)
   );

   // ----------------------------------------------------------------
   // software reset delay after an illegal enable code
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n || sysrst_r) begin
         sreset_busy_r <= 1'b0;
         sreset_cnt_r <= 16'h0;
      end else if (en_illegal_wr && !sreset_busy_r) begin
         sreset_busy_r <= 1'b1;
         sreset_cnt_r <= 16'(sreset_cycles - 1);
      end else if (sreset_busy_r && sreset_cnt_r != 16'h0) begin
         sreset_cnt_r <= sreset_cnt_r - 1'b1;
      end
   end

   // reset-cause flags; hardware set wins over software clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rst_flags_r <= 4'h0;
      end else begin
         if (wr_flags) begin
            rst_flags_r <= w_data_r[3:0];
         end
         if (en_illegal_wr) begin
            rst_flags_r[wdt_pkg::wdtreg_bit] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // power modes
   // ----------------------------------------------------------------
   logic wake_pin, wake_irq;
   assign wake_pin = |(port_a_wake_enable_r & port_a_prev_r &
      ~port_a_in);
   assign wake_irq = irq_request && irq_armed_r;
   assign core_halted = mode_r != wdt_pkg::mode_run;

   // halt picks mode from idle enables; any wake source returns to run
   always_ff @(posedge clock) begin
      if (!rst_n || sysrst_r) begin
         mode_r <= wdt_pkg::mode_run;
      end else if (halt_evt) begin
         case ({sys_ctrl_r[wdt_pkg::fast_idle_bit],
                sys_ctrl_r[wdt_pkg::slow_idle_bit]})
            2'b00: mode_r <= wdt_pkg::mode_sleep;
            2'b01: mode_r <= wdt_pkg::mode_idle0;
            2'b11: mode_r <= wdt_pkg::mode_idle1;
            default: mode_r <= wdt_pkg::mode_fast_only_idle_mode;
         endcase
      end else if (core_halted && (wake_pin || wake_irq || wdt_ovf)) begin
         mode_r <= wdt_pkg::mode_run;
      end
   end

   // port a history for edge detection
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         port_a_prev_r <= '1;
      end else begin
         port_a_prev_r <= port_a_in;
      end
   end

   // request already set at halt cannot wake the part
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq_armed_r <= 1'b0;
      end else if (halt_evt) begin
         irq_armed_r <= !irq_request;
      end else if (!core_halted) begin
         irq_armed_r <= 1'b0;
      end
   end

   // interrupt wake: enter service or leave pending
   always_ff @(posedge clock) begin
      if (!rst_n || sysrst_r) begin
         take_r <= 1'b0;
         irq_pend_r <= 1'b0;
      end else begin
         take_r <= 1'b0;
         if (core_halted && wake_irq && irq_enabled && !stack_full) begin
            take_r <= 1'b1;
         end else if (core_halted && wake_irq) begin
            irq_pend_r <= 1'b1;
         end else if (irq_pend_r && irq_enabled && !stack_full) begin
            take_r <= 1'b1;
            irq_pend_r <= 1'b0;
         end
      end
   end

   // clock enables per mode; slow clock kept when counting needed
   always_comb begin
      fast_clock_on = mode_r == wdt_pkg::mode_run ||
         mode_r == wdt_pkg::mode_idle1 ||
         mode_r == wdt_pkg::mode_fast_only_idle_mode;
      sub_clock_on = mode_r == wdt_pkg::mode_run ||
         mode_r == wdt_pkg::mode_idle0 ||
         mode_r == wdt_pkg::mode_idle1;
      slow_watchdog_clock_on = wdt_on ||
         sys_ctrl_r[wdt_pkg::tben_bit];
   end

   // ----------------------------------------------------------------
   // status flags and reset outputs
   // ----------------------------------------------------------------
   // power-down and time-out flags
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pd_r <= 1'b0;
         to_r <= 1'b0;
      end else if (halt_evt) begin
         pd_r <= 1'b1;
         to_r <= 1'b0;
      end else begin
         if (clr_evt) begin
            pd_r <= 1'b0;
            to_r <= 1'b0;
         end
         if (wdt_ovf) begin
            to_r <= 1'b1;
         end
      end
   end

   // full reset on run-mode overflow, pin or delayed bad code;
   // only pc/sp when the overflow arrives while halted
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sysrst_r <= 1'b0;
         pcsp_r <= 1'b0;
      end else begin
         sysrst_r <= (wdt_ovf && !core_halted) || pin_low ||
            (sreset_busy_r && sreset_cnt_r == 16'h0 && !sysrst_r);
         pcsp_r <= wdt_ovf && core_halted;
      end
   end

   assign system_reset = sysrst_r;
   assign pc_sp_reset = pcsp_r;
   assign irq_take = take_r;
   assign irq_pending = irq_pend_r;
   assign power_down_flag = pd_r;
   assign timeout_flag = to_r;

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0;
      case (s_axi_araddr)
         wdt_pkg::wdt_ctrl_off: rd_word[7:0] = wdt_ctrl_r;
         wdt_pkg::rst_flags_off: rd_word[3:0] = rst_flags_r;
         wdt_pkg::sys_ctrl_off: rd_word[3:0] = sys_ctrl_r;
         wdt_pkg::wake_en_off: rd_word[pa_width-1:0] = port_a_wake_enable_r;
         wdt_pkg::status_off: rd_word[7:0] = {irq_pend_r, mode_r,
                                              to_r, pd_r};
         default: rd_word = 32'h0;
      endcase
   end

   // read answer one cycle after address is taken
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= (mapped(s_axi_araddr) &&
            s_axi_araddr != wdt_pkg::cmd_off) ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/wdt_pkg.sv
// package for the watchdog / halt / wake-up block: offsets, fields, resets
// assumes an AXI4-Lite master with 32-bit data and one 100 MHz clock
package wdt_pkg;
   // register byte offsets
   localparam logic [7:0] wdt_ctrl_off = 8'h00;
   localparam logic [7:0] rst_flags_off = 8'h04;
   localparam logic [7:0] sys_ctrl_off = 8'h08;
   localparam logic [7:0] wake_en_off = 8'h0c;
   localparam logic [7:0] status_off = 8'h10;
   localparam logic [7:0] cmd_off = 8'h14;
   // watchdog_control fields and reset
   localparam int en_lsb = 3;
   localparam int sel_lsb = 0;
   localparam logic [7:0] wdt_ctrl_rst = 8'h52;
   localparam logic [4:0] en_off_code = 5'h15;
   localparam logic [4:0] en_on_code = 5'h0a;
   // reset_cause_flags bit positions
   localparam int wdtreg_bit = 0;
   localparam int lvreg_bit = 1;
   localparam int lv_bit = 2;
   localparam int rstreg_bit = 3;
   // system control bits (fast idle, slow idle, source select, timebase)
   localparam int fast_idle_bit = 0;
   localparam int slow_idle_bit = 1;
   localparam int osc_sel_bit = 2;
   localparam int tben_bit = 3;
   localparam logic [3:0] sys_ctrl_rst = 4'h0;
   // command bits written to cmd register
   localparam int cmd_clear_bit = 0;
   localparam int cmd_halt_bit = 1;
   // timing: software reset delay and slow clock
   localparam int sreset_delay_ns = 1000;
   localparam int clk_period_ns = 10;
   localparam int sreset_cycles = sreset_delay_ns / clk_period_ns;
   localparam int slow_clk_hz = 32768;
   // power modes, one-hot
   typedef enum logic [4:0] {
      mode_run = 5'b00001,
      mode_sleep = 5'b00010,
      mode_idle0 = 5'b00100,
      mode_idle1 = 5'b01000,
      mode_fast_only_idle_mode = 5'b10000
   } pmode_e;
endpackage

// >>> rtl/wdt_counter.sv
// watchdog synchronous binary counter with selectable overflow tap
// assumes slow_tick is a one-cycle pulse per slow clock period
`timescale 1ns/1ps
`default_nettype none
module wdt_counter #(
   parameter int width = 18
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // control
   input wire logic slow_tick,
   input wire logic run,
   input wire logic clear,
   input wire logic [2:0] period_sel,
   // result
   output logic overflow
);
   logic [width-1:0] count_r;

   // tap index for each period code
   function automatic logic [4:0] tap_of(input logic [2:0] s);
      case (s)
         3'h0: tap_of = 5'h08;
         3'h1: tap_of = 5'h0a;
         3'h2: tap_of = 5'h0c;
         3'h3: tap_of = 5'h0e;
         3'h4: tap_of = 5'h0f;
         3'h5: tap_of = 5'h10;
         3'h6: tap_of = 5'h11;
         default: tap_of = 5'h12;
      endcase
   endfunction

   logic [width:0] limit;
   assign limit = (width+1)'(1) << tap_of(period_sel);

   // count slow ticks; any clear restarts from zero
   always_ff @(posedge clock) begin
      if (!rst_n || clear || overflow) begin
         count_r <= '0;
      end else if (run && slow_tick) begin
         count_r <= count_r + 1'b1;
      end
   end

   // overflow on the tick that completes the selected count
   assign overflow = run && slow_tick && !clear &&
                     ({1'b0, count_r} == limit - 1'b1);
endmodule
`default_nettype wire

// >>> testbench/wdt_halt_wake_sva.sv
// checker for the halt, wake-up and watchdog block, top ports only
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module wdt_halt_wake_sva (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // inputs
   input wire logic halt_instr,
   input wire logic watchdog_clear_instruction,
   input wire logic reset_pin_selected,
   input wire logic external_reset_pin_n,
   input wire logic irq_enabled,
   input wire logic stack_full,
   // outputs
   input wire logic fast_clock_on,
   input wire logic sub_clock_on,
   input wire logic core_halted,
   input wire logic system_reset,
   input wire logic pc_sp_reset,
   input wire logic irq_take,
   input wire logic irq_pending,
   input wire logic power_down_flag,
   input wire logic timeout_flag
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ----------------
   // halt entry, clock, reset and interrupt checks
   // ----------------
   sequence s_halt_go;
      halt_instr && !core_halted && !system_reset && !pc_sp_reset;
   endsequence
   sequence s_halt_state;
      core_halted && power_down_flag && !timeout_flag;
   endsequence
   property p_halt_enter;
      s_halt_go |=> s_halt_state;
   endproperty
   a_halt_enter: assert property (p_halt_enter)
      else $error("halt entry state wrong");
   property p_run_clocks;
      !core_halted |-> fast_clock_on && sub_clock_on;
   endproperty
   a_run_clocks: assert property (p_run_clocks)
      else $error("clock stopped while running");
   // clocks fixed while halted
   property p_halt_hold;
      core_halted && $past(core_halted) |->
         $stable({fast_clock_on, sub_clock_on});
   endproperty
   a_halt_hold: assert property (p_halt_hold)
      else $error("halt clocks changed");
   property p_pin_reset;
      reset_pin_selected && !external_reset_pin_n |=> system_reset;
   endproperty
   a_pin_reset: assert property (p_pin_reset)
      else $error("reset pin gave no reset");
   property p_clear_pd;
      watchdog_clear_instruction && !halt_instr |=> !power_down_flag;
   endproperty
   a_clear_pd: assert property (p_clear_pd)
      else $error("power-down flag not cleared");
   property p_ovf_halt;
      pc_sp_reset |-> $past(core_halted) ##[0:2] (timeout_flag && !core_halted);
   endproperty
   a_ovf_halt: assert property (p_ovf_halt)
      else $error("halted overflow wrong");
   property p_one_kind;
      system_reset |-> !pc_sp_reset;
   endproperty
   a_one_kind: assert property (p_one_kind)
      else $error("both reset kinds at once");
   property p_irq_go;
      irq_pending && irq_enabled && !stack_full && !core_halted |->
         ##[0:2] irq_take;
   endproperty
   a_irq_go: assert property (p_irq_go)
      else $error("pending request not taken");
   property p_take_ok;
      irq_take |-> $past(irq_enabled) && !$past(stack_full);
   endproperty
   a_take_ok: assert property (p_take_ok)
      else $error("entry taken without room");
endmodule
bind wdt_halt_wake wdt_halt_wake_sva chk_u (.clock, .rst_n, .halt_instr,
   .watchdog_clear_instruction, .reset_pin_selected, .external_reset_pin_n,
   .irq_enabled, .stack_full, .fast_clock_on, .sub_clock_on, .core_halted,
   .system_reset, .pc_sp_reset, .irq_take, .irq_pending, .power_down_flag,
   .timeout_flag);
`default_nettype wire

// >>> testbench/watchdog_halt_wakeup_bench.sv
// self-checking bench for the halt, wake-up and watchdog block
// assumes the design's register map and bus timing
`timescale 1ns/1ps
`default_nettype none
module watchdog_halt_wakeup_bench;
   localparam int src = 4;
   logic clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr, port_a_in;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp_q, tick_src;
   logic halt_instr, watchdog_clear_instruction, internal_low_osc_tick;
   logic external_low_crystal_tick, reset_pin_selected, external_reset_pin_n;
   logic irq_request, irq_enabled, stack_full, fast_clock_on, sub_clock_on;
   logic slow_watchdog_clock_on, core_halted, system_reset, pc_sp_reset;
   logic irq_take, irq_pending, power_down_flag, timeout_flag, ph;
   logic [15:0] seed;
   logic [2:0] pin;
   int err_count, tests_run, cyc, ticks, t0, n;
   wdt_halt_wake #(.sreset_cycles(src)) dut_u (.clock, .rst_n,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .halt_instr, .watchdog_clear_instruction,
      .internal_low_osc_tick, .external_low_crystal_tick,
      .reset_pin_selected, .external_reset_pin_n, .port_a_in, .irq_request,
      .irq_enabled, .stack_full, .fast_clock_on, .sub_clock_on,
      .slow_watchdog_clock_on, .core_halted, .system_reset, .pc_sp_reset,
      .irq_take, .irq_pending, .power_down_flag, .timeout_flag);
   // ----------------
   // clock, slow ticks and hang limit
   // ----------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // both on: internal ticks every cycle
   always @(posedge clock) begin
      ph <= ~ph;
      internal_low_osc_tick <= tick_src[0] & (!ph | tick_src[1]);
      external_low_crystal_tick <= tick_src[1] & !ph;
      if (tick_src != 2'b00 && !ph) ticks <= ticks + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ----------------
   // helpers
   // ----------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [4:0] mode_of(input int i);
      case (i)
         0: return wdt_pkg::mode_sleep;
         1: return wdt_pkg::mode_fast_only_idle_mode;
         2: return wdt_pkg::mode_idle0;
         default: return wdt_pkg::mode_idle1;
      endcase
   endfunction
   function automatic logic pick(input int w);
      case (w)
         0: return system_reset;
         1: return pc_sp_reset;
         2: return irq_take;
         default: return !core_halted;
      endcase
   endfunction
   task automatic wait_hi(input int w, input int lim, output int k);
      for (k = 0; k < lim && pick(w) !== 1'b1; k++) @(posedge clock);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok = 1'b0, w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (s_axi_bvalid !== 1'b1);
      rsp_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic axi_rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clock);
      rd_q = s_axi_rdata;
      rsp_q = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask
   task automatic pulse(input int w);
      if (w == 0) halt_instr <= 1'b1;
      else watchdog_clear_instruction <= 1'b1;
      @(posedge clock);
      halt_instr <= 1'b0;
      watchdog_clear_instruction <= 1'b0;
      repeat (2) @(posedge clock);
   endtask
   task automatic pin_wake();
      port_a_in[pin] <= 1'b0;
      wait_hi(3, 10, n);
      port_a_in <= 8'hff;
      @(posedge clock);
   endtask
   task automatic report_and_stop();
      $display("counts: %0d checks, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ----------------
   // main sequence
   // ----------------
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, halt_instr, ph} = 4'h0;
      {watchdog_clear_instruction, reset_pin_selected, stack_full} = 3'h0;
      {irq_request, irq_enabled, external_reset_pin_n} = 3'h7;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      port_a_in = 8'hff;
      tick_src = 2'b00;
      {err_count, tests_run, cyc, ticks} = '0;
      seed = 16'd46418;
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      axi_rd(wdt_pkg::wdt_ctrl_off);
      chk(rd_q, 32'(wdt_pkg::wdt_ctrl_rst));
      chk(32'(slow_watchdog_clock_on), 32'h1);
      axi_rd(8'h18);
      chk(32'(rsp_q), 32'h2);
      $display("reset values done");
      // every idle-enable pair, woken by a random enabled pin
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         pin = seed[2:0];
         axi_wr(wdt_pkg::wake_en_off, 32'(8'h01 << pin));
         axi_wr(wdt_pkg::sys_ctrl_off, 32'(i));
         pulse(0);
         chk(32'({fast_clock_on, sub_clock_on, core_halted, power_down_flag,
            timeout_flag}), 32'({i[0], i[1], 3'b110}));
         axi_rd(wdt_pkg::status_off);
         chk(32'(rd_q[6:2]), 32'(mode_of(i)));
         pin_wake();
         chk(32'(core_halted), 32'h0);
         pulse(1);
         chk(32'(power_down_flag), 32'h0);
      end
      $display("halt modes done");
      pulse(0);
      wait_hi(3, 12, n);
      chk(32'(core_halted), 32'h1);
      irq_request <= 1'b0;
      pin_wake();
      pulse(0);
      irq_request <= 1'b1;
      wait_hi(2, 10, n);
      chk(32'(irq_take), 32'h1);
      irq_request <= 1'b0;
      irq_enabled <= 1'b0;
      pulse(0);
      irq_request <= 1'b1;
      wait_hi(3, 10, n);
      chk(32'({core_halted, irq_pending}), 32'h1);
      irq_request <= 1'b0;
      irq_enabled <= 1'b1;
      wait_hi(2, 10, n);
      chk(32'(irq_take), 32'h1);
      $display("interrupt wake done");
      // shortest period, counted from the clear
      axi_wr(wdt_pkg::wdt_ctrl_off, 32'h50);
      pulse(1);
      tick_src <= 2'b01;
      t0 = ticks;
      wait_hi(0, 1000, n);
      chk(32'(ticks - t0 inside {[254:258]}), 32'h1);
      chk(32'(timeout_flag), 32'h1);
      axi_rd(wdt_pkg::wdt_ctrl_off);
      chk(rd_q, 32'h52);
      axi_wr(wdt_pkg::sys_ctrl_off, 32'h4);
      axi_wr(wdt_pkg::wdt_ctrl_off, 32'h50);
      tick_src <= 2'b11;
      pulse(0);
      t0 = ticks;
      wait_hi(1, 1000, n);
      chk(32'(ticks - t0 inside {[253:258]}), 32'h1);
      axi_wr(wdt_pkg::wdt_ctrl_off, 32'ha8);
      chk(32'(slow_watchdog_clock_on), 32'h0);
      wait_hi(0, 700, n);
      chk(n, 700);
      $display("watchdog count done");
      tick_src <= 2'b00;
      axi_wr(wdt_pkg::wdt_ctrl_off, 32'h00);
      wait_hi(0, 20, n);
      chk(32'(n <= src), 32'h1);
      axi_rd(wdt_pkg::rst_flags_off);
      chk(32'(rd_q[0]), 32'h1);
      axi_wr(wdt_pkg::rst_flags_off, 32'h0);
      axi_rd(wdt_pkg::rst_flags_off);
      chk(32'(rd_q[0]), 32'h0);
      reset_pin_selected <= 1'b1;
      external_reset_pin_n <= 1'b0;
      @(posedge clock);
      external_reset_pin_n <= 1'b1;
      wait_hi(0, 3, n);
      chk(32'(system_reset), 32'h1);
      reset_pin_selected <= 1'b0;
      $display("illegal field and pin reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
